// >>> logic/diag_alert_consts.svh
// Offsets, field positions, reset values and codes of the alert status registers
`ifndef DIAG_ALERT_CONSTS_SVH
`define DIAG_ALERT_CONSTS_SVH

`define REG_ADDR_W            8
`define REG_DATA_W            16

`define SELFTEST_ALERT_OFFSET 8'h06
`define ALERT_SUMMARY_OFFSET  8'h07

`define SELFTEST_ALERT_RESET  16'h0000
`define ALERT_SUMMARY_RESET   16'h0000
`define READ_DATA_RESET       16'h0000

`define POS_ZERO_SCALE_FAIL   3
`define POS_FULL_SCALE_FAIL   2
`define POS_CONV_ZS           3
`define POS_CONV_FS           2
`define POS_CMP_ACC_OV        1
`define POS_CMP_ACC_UV        0
`define SELFTEST_ALERT_BITS   4

`define POS_CONV_CELL_OV      15
`define POS_CMP_CELL_OV       14
`define POS_CONV_CELL_UV      13
`define POS_CMP_CELL_UV       12
`define POS_CONV_AUX_OV       11
`define POS_CMP_AUX_OV        10
`define POS_CONV_AUX_UV       9
`define POS_CMP_AUX_UV        8
`define POS_CAL_LSB           0
`define POS_CAL_MSB           4
`define CAL_ALERT_BITS        5
`define SUMMARY_BITS          8

`define CELL_COUNT            14
`define AUX_COUNT             6

`define SCAN_CFG_W            3
`define SCAN_CFG_ACC_A        3'h1
`define SCAN_CFG_ACC_B        3'h2

`endif

// >>> logic/diag_alert_pkg.sv
// Types shared by the alert status register logic
package diag_alert_pkg;

  typedef logic [7:0]  reg_addr_t;
  typedef logic [15:0] reg_data_t;
  typedef logic [13:0] cell_vec_t;
  typedef logic [5:0]  aux_vec_t;
  typedef logic [2:0]  scan_cfg_t;
  typedef logic [4:0]  cal_vec_t;

  // Kind of register access decoded in a cycle
  typedef enum logic [1:0]
  {
    ACC_NONE     = 2'b00,
    ACC_SELFTEST = 2'b01,
    ACC_SUMMARY  = 2'b10,
    ACC_UNMAPPED = 2'b11
  } access_kind_t;

  typedef struct packed
  {
    logic flag;
  } sticky_state_t;

  typedef struct packed
  {
    logic [7:0] summary;
    cal_vec_t   cal;
    reg_data_t  rd_data;
    logic       rd_valid;
    logic       wr_refused;
  } diag_state_t;

endpackage

// >>> logic/sticky_alert_bit.sv
// One sticky alert flag: hardware sets it, a written zero clears it
`timescale 1ns/100ps
`include "diag_alert_consts.svh"

module sticky_alert_bit
(
  input  wire logic clk_sys,    // System clock
  input  wire logic reset,      // Synchronous reset, active high
  input  wire logic set_pulse,  // Failure reported this cycle
  input  wire logic clear_req,  // Software wrote zero to this bit
  output logic      flag        // Held alert value
);
  import diag_alert_pkg::*;

  sticky_state_t state;
  sticky_state_t next_state;

  always_comb
  begin
    next_state = state;
    // A failure in the clearing cycle keeps the bit set
    next_state.flag = (state.flag & ~clear_req) | set_pulse;
    if (reset)
    begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state <= next_state;
  end

  assign flag = state.flag;

endmodule // sticky_alert_bit

// >>> logic/diag_alert_status_regs.sv
// Self-test and accuracy alert bits and the alert-summary breakout register
`timescale 1ns/100ps
`include "diag_alert_consts.svh"

// Overview of operation
// - Zero-scale self-test failure sets alert bit 3
// - Full-scale self-test failure sets alert bit 2
// - Self-tests update only while enable is set
// - Four alert bits sticky, cleared by writing 0
// - Writing 1 leaves these alert bits unchanged
// - Accuracy overvoltage failure sets alert bit 1
// - Accuracy undervoltage failure sets alert bit 0
// - Accuracy diagnostics need scan 001/010 and enable
// - Read-only alert summary at offset 0x07
// - Summary pairs in bits 15-8, calibration 4-0
// - Bit 15 ORs cell converter OV alerts, held to next acquisition
module diag_alert_status_regs
(
  input  wire logic                      clk_sys,        // System clock, 10 MHz
  input  wire logic                      reset,          // Synchronous reset, active high
  // Register port from the serial host link
  input  wire diag_alert_pkg::reg_addr_t reg_addr,       // Register offset
  input  wire logic                      reg_wr,         // Write strobe, one cycle
  input  wire diag_alert_pkg::reg_data_t reg_wdata,      // Write data
  input  wire logic                      reg_rd,         // Read strobe, one cycle
  output diag_alert_pkg::reg_data_t      reg_rdata,      // Read data, registered
  output logic                           reg_rvalid,     // Read data valid, one cycle
  output logic                           reg_wr_refused, // Write to read-only or unmapped
  // Control bits held elsewhere in the device
  input  wire logic                      conv_selftest_enable,       // Self-test enable
  input  wire diag_alert_pkg::scan_cfg_t scan_configuration_field,   // Scan configuration
  input  wire logic                      comparator_accuracy_enable, // Accuracy diag enable
  // Results from the acquisition engines
  input  wire logic                      acq_done,       // Acquisition finished, one cycle
  input  wire logic                      zs_selftest_fail, // Zero-scale self-test failed
  input  wire logic                      fs_selftest_fail, // Full-scale self-test failed
  input  wire logic                      seq_end,        // End of sequence, one cycle
  input  wire logic                      acc_over_fail,  // Accuracy OV diagnostic failed
  input  wire logic                      acc_under_fail, // Accuracy UV diagnostic failed
  input  wire diag_alert_pkg::cell_vec_t per_cell_conv_over_alerts, // Cell converter OV
  input  wire diag_alert_pkg::cell_vec_t per_cell_cmp_over_alerts,  // Cell comparator OV
  input  wire diag_alert_pkg::cell_vec_t per_cell_conv_under_alerts, // Cell converter UV
  input  wire diag_alert_pkg::cell_vec_t per_cell_cmp_under_alerts, // Cell comparator UV
  input  wire diag_alert_pkg::aux_vec_t  aux_conv_over_alerts,  // Aux converter OV
  input  wire diag_alert_pkg::aux_vec_t  aux_cmp_over_alerts,   // Aux comparator OV
  input  wire diag_alert_pkg::aux_vec_t  aux_conv_under_alerts, // Aux converter UV
  input  wire diag_alert_pkg::aux_vec_t  aux_cmp_under_alerts,  // Aux comparator UV
  input  wire diag_alert_pkg::cal_vec_t  cal_alerts,     // Five calibration alerts
  // Register contents for the status logic
  output logic [3:0]                     selftest_alerts, // Sticky alert bits 3..0
  output diag_alert_pkg::reg_data_t      alert_summary_breakout // Summary register
);
  import diag_alert_pkg::*;

  diag_state_t  state;
  diag_state_t  next_state;
  access_kind_t wr_kind;
  access_kind_t rd_kind;

  logic [3:0]   alert_set;
  logic [3:0]   alert_clear;
  logic [3:0]   alert_flags;
  logic         selftest_run;
  logic         accuracy_run;
  logic         scan_cfg_ok;
  logic [7:0]   summary_now;
  reg_data_t    summary_word;
  reg_data_t    selftest_word;

  // Address decode of the host link access
  function automatic access_kind_t decode(input logic strobe, input reg_addr_t addr);
    access_kind_t kind;
    kind = ACC_NONE;
    if (strobe)
    begin
      if (addr == `SELFTEST_ALERT_OFFSET)
      begin
        kind = ACC_SELFTEST;
      end
      else if (addr == `ALERT_SUMMARY_OFFSET)
      begin
        kind = ACC_SUMMARY;
      end
      else
      begin
        kind = ACC_UNMAPPED;
      end
    end
    return kind;
  endfunction

  assign wr_kind = decode(reg_wr, reg_addr);
  assign rd_kind = decode(reg_rd, reg_addr);

  // Self-test results are taken at the end of an enabled acquisition
  assign selftest_run = acq_done & conv_selftest_enable;

  // Accuracy diagnostics only count in the two scan modes that run them
  assign scan_cfg_ok  = (scan_configuration_field == `SCAN_CFG_ACC_A)
                      | (scan_configuration_field == `SCAN_CFG_ACC_B);
  assign accuracy_run = seq_end & scan_cfg_ok & comparator_accuracy_enable;

  always_comb
  begin
    alert_set = 4'h0;
    alert_set[`POS_CONV_ZS]    = selftest_run & zs_selftest_fail;
    alert_set[`POS_CONV_FS]    = selftest_run & fs_selftest_fail;
    alert_set[`POS_CMP_ACC_OV] = accuracy_run & acc_over_fail;
    alert_set[`POS_CMP_ACC_UV] = accuracy_run & acc_under_fail;
  end

  // Only a written zero clears; a written one is ignored
  always_comb
  begin
    alert_clear = 4'h0;
    if (wr_kind == ACC_SELFTEST)
    begin
      alert_clear = ~reg_wdata[3:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `SELFTEST_ALERT_BITS; gi++)
    begin : g_alert
      sticky_alert_bit u_bit
      (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .set_pulse (alert_set[gi]),
        .clear_req (alert_clear[gi]),
        .flag      (alert_flags[gi])
      );
    end
  endgenerate

  // Present value of each summary pair, before acquisition holding
  always_comb
  begin
    summary_now = 8'h00;
    summary_now[`POS_CONV_CELL_OV - `SUMMARY_BITS] = |per_cell_conv_over_alerts;
    summary_now[`POS_CMP_CELL_OV - `SUMMARY_BITS]  = |per_cell_cmp_over_alerts;
    summary_now[`POS_CONV_CELL_UV - `SUMMARY_BITS] = |per_cell_conv_under_alerts;
    summary_now[`POS_CMP_CELL_UV - `SUMMARY_BITS]  = |per_cell_cmp_under_alerts;
    summary_now[`POS_CONV_AUX_OV - `SUMMARY_BITS]  = |aux_conv_over_alerts;
    summary_now[`POS_CMP_AUX_OV - `SUMMARY_BITS]   = |aux_cmp_over_alerts;
    summary_now[`POS_CONV_AUX_UV - `SUMMARY_BITS]  = |aux_conv_under_alerts;
    summary_now[`POS_CMP_AUX_UV - `SUMMARY_BITS]   = |aux_cmp_under_alerts;
  end

  always_comb
  begin
    summary_word = `ALERT_SUMMARY_RESET;
    summary_word[15:8] = state.summary;
    summary_word[`POS_CAL_MSB:`POS_CAL_LSB] = state.cal;
  end

  always_comb
  begin
    selftest_word = `SELFTEST_ALERT_RESET;
    selftest_word[3:0] = alert_flags;
  end

  always_comb
  begin
    next_state = state;

    // A set bit stays until an acquisition sees all its conditions gone
    if (acq_done)
    begin
      next_state.summary = summary_now;
    end
    else
    begin
      next_state.summary = state.summary | summary_now;
    end
    next_state.cal = cal_alerts;

    // Read data is captured at the strobe and shown for one cycle
    next_state.rd_valid = reg_rd;
    next_state.rd_data  = `READ_DATA_RESET;
    case (rd_kind)
      ACC_SELFTEST:
      begin
        next_state.rd_data = selftest_word;
      end
      ACC_SUMMARY:
      begin
        next_state.rd_data = summary_word;
      end
      ACC_UNMAPPED:
      begin
        next_state.rd_data = `READ_DATA_RESET;
      end
      default:
      begin
        next_state.rd_data = `READ_DATA_RESET;
      end
    endcase

    // Summary writes have no effect; flag the refusal for one cycle
    case (wr_kind)
      ACC_SUMMARY:
      begin
        next_state.wr_refused = 1'b1;
      end
      ACC_UNMAPPED:
      begin
        next_state.wr_refused = 1'b1;
      end
      default:
      begin
        next_state.wr_refused = 1'b0;
      end
    endcase

    if (reset)
    begin
      next_state.summary    = 8'h00;
      next_state.cal        = 5'h00;
      next_state.rd_data    = `READ_DATA_RESET;
      next_state.rd_valid   = 1'b0;
      next_state.wr_refused = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state <= next_state;
  end

  assign reg_rdata              = state.rd_data;
  assign reg_rvalid             = state.rd_valid;
  assign reg_wr_refused         = state.wr_refused;
  assign selftest_alerts        = alert_flags;
  assign alert_summary_breakout = summary_word;

endmodule // diag_alert_status_regs

// >>> tb/host_link_model.sv
// Host side model issuing register reads and writes on the strobe port
`timescale 1ns/100ps
module host_link_model
  import diag_alert_pkg::*;
(
  input  wire logic      clk_sys,    // System clock
  output reg_addr_t      reg_addr,   // Offset
  output logic           reg_wr,     // Write strobe
  output reg_data_t      reg_wdata,  // Write data
  output logic           reg_rd,     // Read strobe
  input  wire reg_data_t reg_rdata,  // Read data
  input  wire logic      reg_rvalid  // Read data valid
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse so stale values cannot pass
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input reg_addr_t a, output reg_data_t d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(posedge clk_sys);
      if (reg_rvalid === 1'b1)
      begin
        d = reg_rdata;
        ok = 1'b1;
      end
    end
  endtask
endmodule // host_link_model

// >>> tb/diag_alert_status_regs_chk.sv
// Concurrent checks on the alert status register block
`timescale 1ns/100ps
`include "diag_alert_consts.svh"
module diag_alert_status_regs_chk
  import diag_alert_pkg::*;
(
  input wire logic      clk_sys,                    // Clock
  input wire logic      reset,                      // Reset
  input wire reg_addr_t reg_addr,                   // Offset
  input wire logic      reg_wr,                     // Write strobe
  input wire reg_data_t reg_wdata,                  // Write data
  input wire logic      reg_rd,                     // Read strobe
  input wire reg_data_t reg_rdata,                  // Read data
  input wire logic      reg_rvalid,                 // Read valid
  input wire logic      conv_selftest_enable,       // Self-test enable
  input wire scan_cfg_t scan_configuration_field,   // Scan setting
  input wire logic      comparator_accuracy_enable, // Accuracy enable
  input wire logic      acq_done,                   // Acquisition end
  input wire logic      zs_selftest_fail,           // Zero-scale fail
  input wire logic      seq_end,                    // Sequence end
  input wire logic      acc_over_fail,              // Accuracy OV fail
  input wire cell_vec_t per_cell_conv_over_alerts,  // Cell OV alerts
  input wire logic [3:0] selftest_alerts,           // Sticky flags
  input wire logic      reg_wr_refused,             // Write refused
  input wire reg_data_t alert_summary_breakout      // Summary
);
  logic ov_cause;
  logic clr3;
  assign ov_cause = seq_end && comparator_accuracy_enable && acc_over_fail &&
    (scan_configuration_field == 3'h1 || scan_configuration_field == 3'h2);
  assign clr3 = reg_wr && reg_addr == 8'h06 && !reg_wdata[3];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_zs_set: assert property (acq_done && conv_selftest_enable && zs_selftest_fail
    |=> selftest_alerts[3]) else $error("zero-scale flag not set");
  chk_zs_hold: assert property (!(acq_done && conv_selftest_enable) && !clr3
    |=> $stable(selftest_alerts[3])) else $error("zero-scale flag moved");
  chk_ones_keep: assert property (reg_wr && reg_addr == 8'h06 && reg_wdata[3:0] == 4'hf
    |=> ($past(selftest_alerts) & ~selftest_alerts) == 4'h0) else $error("flag lost");
  chk_ov_set: assert property (ov_cause |=> selftest_alerts[1])
    else $error("accuracy OV flag not set");
  chk_acc_gate: assert property ($rose(selftest_alerts[1]) |-> $past(ov_cause))
    else $error("accuracy OV flag without cause");
  chk_read_sum: assert property (reg_rd && reg_addr == 8'h07
    |=> reg_rvalid && reg_rdata == $past(alert_summary_breakout)) else $error("bad read");
  chk_rsvd_zero: assert property (alert_summary_breakout[7:5] == 3'h0)
    else $error("reserved bits set");
  chk_cell_or: assert property (|per_cell_conv_over_alerts
    |=> alert_summary_breakout[15]) else $error("cell OV summary missing");
  chk_wr_refuse: assert property (reg_wr && reg_addr != 8'h06 |=> reg_wr_refused)
    else $error("refused write not flagged");
  cover property (ov_cause);
  cover property (clr3 && selftest_alerts[3]);
  cover property (reg_rvalid && reg_rdata[15]);
endmodule // diag_alert_status_regs_chk
bind diag_alert_status_regs diag_alert_status_regs_chk i_diag_alert_status_regs_chk (.*);

// >>> tb/diag_alert_status_regs_tb_top.sv
// Testbench for the alert status register block
`timescale 1ns/100ps
module diag_alert_status_regs_tb_top;
  import diag_alert_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  reg_addr_t reg_addr;
  reg_data_t reg_wdata, reg_rdata, alert_summary_breakout;
  logic reg_wr, reg_rd, reg_rvalid, reg_wr_refused;
  logic [3:0] selftest_alerts;
  logic conv_selftest_enable = 0, comparator_accuracy_enable = 0, acq_done = 0;
  logic zs_selftest_fail = 0, fs_selftest_fail = 0, seq_end = 0;
  logic acc_over_fail = 0, acc_under_fail = 0;
  scan_cfg_t scan_configuration_field = 3'h0;
  cal_vec_t cal_alerts = 5'h00;
  cell_vec_t per_cell_conv_over_alerts = 0, per_cell_cmp_over_alerts = 0;
  cell_vec_t per_cell_conv_under_alerts = 0, per_cell_cmp_under_alerts = 0;
  aux_vec_t aux_conv_over_alerts = 0, aux_cmp_over_alerts = 0;
  aux_vec_t aux_conv_under_alerts = 0, aux_cmp_under_alerts = 0;
  int bad_count = 0;
  int total_checks = 0;
  diag_alert_status_regs i_diag_alert_status_regs (.*);
  host_link_model i_host_link_model (.*);
  always #50 clk_sys = ~clk_sys;
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rd_chk(input reg_addr_t a, input reg_data_t exp);
    reg_data_t d;
    logic ok;
    i_host_link_model.rd(a, d, ok);
    total_checks++;
    if (!ok)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      conclude();
    end
    if (d !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, d, exp);
    end
  endtask
  task automatic pulse(input logic seq);
    @(posedge clk_sys);
    acq_done <= !seq;
    seq_end <= seq;
    @(posedge clk_sys);
    acq_done <= 1'b0;
    seq_end <= 1'b0;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(8'h06, 16'h0000);
    rd_chk(8'h07, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    zs_selftest_fail <= 1'b1;
    fs_selftest_fail <= 1'b1;
    pulse(1'b0);
    rd_chk(8'h06, 16'h0000);
    conv_selftest_enable <= 1'b1;
    fs_selftest_fail <= 1'b0;
    pulse(1'b0);
    rd_chk(8'h06, 16'h0008);
    zs_selftest_fail <= 1'b0;
    fs_selftest_fail <= 1'b1;
    pulse(1'b0);
    rd_chk(8'h06, 16'h000c);
    i_host_link_model.wr(8'h06, 16'hffff);
    rd_chk(8'h06, 16'h000c);
    i_host_link_model.wr(8'h06, 16'h0004);
    rd_chk(8'h06, 16'h0004);
    conv_selftest_enable <= 1'b0;
    acc_over_fail <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      i_host_link_model.wr(8'h06, 16'h0000);
      scan_configuration_field <= (i == 8) ? 3'h1 : 3'(i);
      comparator_accuracy_enable <= (i < 8);
      acc_under_fail <= (i == 2);
      pulse(1'b1);
      rd_chk(8'h06, (i == 1 || i == 2) ? 16'h0002 | 16'(i == 2) : 16'h0000);
    end
    per_cell_conv_over_alerts <= 14'h2000;
    per_cell_conv_under_alerts <= 14'h0001;
    aux_conv_over_alerts <= 6'h20;
    aux_conv_under_alerts <= 6'h01;
    cal_alerts <= 5'h15;
    rd_chk(8'h07, 16'haa15);
    i_host_link_model.wr(8'h07, 16'hffff);
    @(negedge clk_sys);
    total_checks++;
    if (reg_wr_refused !== 1'b1)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, reg_wr_refused, 1'b1);
    end
    per_cell_conv_over_alerts <= 14'h0000;
    per_cell_conv_under_alerts <= 14'h0000;
    aux_conv_over_alerts <= 6'h00;
    aux_conv_under_alerts <= 6'h00;
    per_cell_cmp_over_alerts <= 14'h0100;
    per_cell_cmp_under_alerts <= 14'h0001;
    aux_cmp_over_alerts <= 6'h01;
    aux_cmp_under_alerts <= 6'h02;
    rd_chk(8'h07, 16'hff15);
    pulse(1'b0);
    rd_chk(8'h07, 16'h5515);
    conclude();
  end
endmodule // diag_alert_status_regs_tb_top
